// >>> fws_pkg.sv
// Shared constants and types for the flash program/suspend host controller.
// Assumes a 10 MHz system clock; all pin timing is derived from it here.
package fws_pkg;

  // ----------------------------------------------------------------------
  // Clock and strobe timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_SETUP_NS    = 50;   // Address/data settle before strobe
  localparam int T_STROBE_NS   = 100;  // Least strobe low time
  localparam int T_RECOVER_NS  = 50;   // Least strobe high time between cycles

  localparam int SETUP_RAW   = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_RAW  = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_RAW = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC   = (SETUP_RAW < 1) ? 1 : SETUP_RAW;
  localparam int STROBE_CYC  = (STROBE_RAW < 1) ? 1 : STROBE_RAW;
  localparam int RECOVER_CYC = (RECOVER_RAW < 1) ? 1 : RECOVER_RAW;
  localparam int TIMER_W     = 8;

  // ----------------------------------------------------------------------
  // Operation status byte layout
  // ----------------------------------------------------------------------
  localparam int OST_READY   = 7;
  localparam int OST_ESUSP   = 6;
  localparam int OST_EERR    = 5;
  localparam int OST_PERR    = 4;
  localparam int OST_VLOW    = 3;
  localparam int OST_WSUSP   = 2;
  localparam int OST_LOCK    = 1;
  localparam int OST_RSVD    = 0;
  localparam logic [7:0] OST_USE_MASK = 8'hFE;
  localparam logic [7:0] OST_RESET    = 8'h00;

  // ----------------------------------------------------------------------
  // Command codes that are fixed for the part
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;

  // ----------------------------------------------------------------------
  // User operations
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_PROGRAM,
    OP_SUSPEND,
    OP_RESUME,
    OP_READ_STATUS,
    OP_READ_ARRAY,
    OP_CLEAR
  } fws_op_type;

endpackage

// >>> fws_bus_cycle.sv
// Single asynchronous strobe cycle (write or read) on the flash pins.
// Assumes the flash pins are sampled by the device with no clock of its own.
`timescale 1ns/1ns
`default_nettype none

module fws_bus_cycle
  import fws_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Cycle request
  input  wire logic              req_i,
  input  wire logic              write_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output      logic              ready_o,
  output      logic              done_o,
  output      logic [DATA_W-1:0] rdata_o,
  // Flash pins
  output      logic              ce_n_o,
  output      logic              we_n_o,
  output      logic              oe_n_o,
  output      logic [ADDR_W-1:0] addr_o,
  output      logic [DATA_W-1:0] dq_o,
  output      logic              dq_oe_n_o,
  input  wire logic [DATA_W-1:0] dq_i
);

  if (STROBE_CYC > 255 || SETUP_CYC > 255 || RECOVER_CYC > 255) begin : g_bad_timing
    $error("strobe timing does not fit the phase counter");
  end

  typedef enum logic [1:0] {B_IDLE, B_SETUP, B_STROBE, B_RECOVER} fws_bus_state_type;

  fws_bus_state_type   state;
  logic [TIMER_W-1:0]  cnt;
  logic                is_write;

  wire last_cnt = (cnt == TIMER_W'(1));

  assign ready_o = (state == B_IDLE);
  assign done_o  = (state == B_RECOVER) && last_cnt;

  // ----------------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------------
  // Data is driven from setup through recovery so it is stable across the
  // rising write strobe, where the device latches it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= B_IDLE;
      cnt       <= '0;
      is_write  <= 1'b0;
      ce_n_o    <= 1'b1;
      we_n_o    <= 1'b1;
      oe_n_o    <= 1'b1;
      addr_o    <= '0;
      dq_o      <= '0;
      dq_oe_n_o <= 1'b1;
      rdata_o   <= '0;
    end else begin
      unique case (state)
        B_IDLE: begin
          if (req_i) begin
            state     <= B_SETUP;
            cnt       <= TIMER_W'(SETUP_CYC);
            is_write  <= write_i;
            addr_o    <= addr_i;
            dq_o      <= wdata_i;
            dq_oe_n_o <= !write_i;
            ce_n_o    <= 1'b0;
          end
        end
        B_SETUP: begin
          cnt <= cnt - TIMER_W'(1);
          if (last_cnt) begin
            state  <= B_STROBE;
            cnt    <= TIMER_W'(STROBE_CYC);
            we_n_o <= !is_write;
            oe_n_o <= is_write;
          end
        end
        B_STROBE: begin
          cnt <= cnt - TIMER_W'(1);
          if (last_cnt) begin
            state   <= B_RECOVER;
            cnt     <= TIMER_W'(RECOVER_CYC);
            we_n_o  <= 1'b1;
            oe_n_o  <= 1'b1;
            rdata_o <= is_write ? rdata_o : dq_i;
          end
        end
        B_RECOVER: begin
          cnt <= cnt - TIMER_W'(1);
          if (last_cnt) begin
            state     <= B_IDLE;
            ce_n_o    <= 1'b1;
            dq_oe_n_o <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule // fws_bus_cycle

`default_nettype wire

// >>> fws_flash_host.sv
// Host controller for a parallel flash: program, suspend/resume, status and
// array reads, status clear, and the lock/supply control levels.
// Assumes user orders arrive synchronous to clk_i and that board circuitry
// turns rp_unlock_o and vpp_en_o into the elevated and supply voltages.
`timescale 1ns/1ns
`default_nettype none

// How it works
// - During suspend only array, status, resume issued.
// - After suspend, read status and test flags.
// - Ignore status bits 6..0 until ready.
// - Reserved status bit masked out when polling.
module fws_flash_host
  import fws_pkg::*;
#(
  parameter int         ADDR_W          = 18,
  parameter int         DATA_W          = 8,
  parameter int         POLL_LIMIT      = 64,
  parameter logic [7:0] CMD_READ_ARRAY  = 8'hFF,
  parameter logic [7:0] CMD_READ_STATUS = 8'h70,
  parameter logic [7:0] CMD_SUSPEND     = 8'hB0,
  parameter logic [7:0] CMD_RESUME      = 8'hD0
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // User orders
  input  wire logic              cmd_valid_i,
  input  wire fws_op_type        cmd_op_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [DATA_W-1:0] cmd_data_i,
  output      logic              cmd_ready_o,
  // User answers
  output      logic              rsp_valid_o,
  output      logic              rsp_refused_o,
  output      logic [7:0]        rsp_status_o,
  output      logic              rsp_flags_valid_o,
  output      logic [DATA_W-1:0] rsp_data_o,
  output      logic              suspended_o,
  // Protection levels requested by the user
  input  wire logic              powerdown_i,
  input  wire logic              unlock_i,
  input  wire logic              write_enable_i,
  // Flash control levels
  output      logic              rp_n_o,
  output      logic              rp_unlock_o,
  output      logic              vpp_en_o,
  // Flash bus pins
  output      logic              ce_n_o,
  output      logic              we_n_o,
  output      logic              oe_n_o,
  output      logic [ADDR_W-1:0] addr_o,
  output      logic [DATA_W-1:0] dq_o,
  output      logic              dq_oe_n_o,
  input  wire logic [DATA_W-1:0] dq_i
);

  if (DATA_W < 8 || POLL_LIMIT < 1 || ADDR_W < 1) begin : g_bad_params
    $error("data must be at least a byte wide and poll limit positive");
  end
  localparam int POLL_W = $clog2(POLL_LIMIT + 1);
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_DATA, ST_STAT_CMD, ST_READ, ST_RESP
  } fws_state_type;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  fws_state_type       state;
  fws_state_type       next_state;
  fws_op_type          op;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   data;
  logic [ADDR_W-1:0]   susp_addr;
  logic [ADDR_W-1:0]   prog_addr;
  logic [POLL_W-1:0]   polls;
  logic                issued;
  logic                refused;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire              op_legal  = (cmd_op_i inside {OP_PROGRAM, OP_SUSPEND, OP_RESUME,
                                                  OP_READ_STATUS, OP_READ_ARRAY, OP_CLEAR});
  wire              susp_ok   = (cmd_op_i == OP_READ_STATUS) || (cmd_op_i == OP_RESUME) ||
                                ((cmd_op_i == OP_READ_ARRAY) && (cmd_addr_i != susp_addr));
  wire              refuse    = !op_legal || (suspended_o && !susp_ok);
  wire              take      = (state == ST_IDLE) && cmd_valid_i;
  wire              in_bus    = (state == ST_CMD) || (state == ST_DATA) ||
                                (state == ST_STAT_CMD) || (state == ST_READ);
  wire              bus_req   = in_bus && !issued;
  wire              bus_ready;
  wire              bus_done;
  wire [DATA_W-1:0] bus_rdata;
  wire [7:0]        op_code   = (op == OP_PROGRAM)     ? CMD_PROGRAM :
                                (op == OP_SUSPEND)     ? CMD_SUSPEND :
                                (op == OP_RESUME)      ? CMD_RESUME :
                                (op == OP_READ_STATUS) ? CMD_READ_STATUS :
                                (op == OP_CLEAR)       ? CMD_CLEAR_STATUS : CMD_READ_ARRAY;
  wire [7:0]        wbyte     = (state == ST_STAT_CMD) ? CMD_READ_STATUS : op_code;
  wire [DATA_W-1:0] bus_wdata = (state == ST_DATA) ? data : DATA_W'(wbyte);
  wire              bus_write = (state != ST_READ);
  wire [7:0]        sbyte     = bus_rdata[7:0];
  wire              susp_seen = sbyte[OST_READY] && (sbyte[OST_WSUSP] || sbyte[OST_ESUSP]);
  wire              poll_more = (op == OP_SUSPEND) && !sbyte[OST_READY] &&
                                (polls != POLL_W'(POLL_LIMIT));
  assign cmd_ready_o = (state == ST_IDLE);
  assign rsp_valid_o = (state == ST_RESP);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // A suspend is always followed by an explicit status command before the
  // poll, so the device is known to be in status mode whatever came before.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:     if (take) next_state = refuse ? ST_RESP : ST_CMD;
      ST_CMD: begin
        if (bus_done) begin
          unique case (op)
            OP_PROGRAM:     next_state = ST_DATA;
            OP_SUSPEND:     next_state = ST_STAT_CMD;
            OP_READ_STATUS: next_state = ST_READ;
            OP_READ_ARRAY:  next_state = ST_READ;
            default:        next_state = ST_RESP;
          endcase
        end
      end
      ST_DATA:     if (bus_done) next_state = ST_RESP;
      ST_STAT_CMD: if (bus_done) next_state = ST_READ;
      ST_READ:     if (bus_done && !poll_more) next_state = ST_RESP;
      ST_RESP:     next_state = ST_IDLE;
      default:     next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    state <= rst_i ? ST_IDLE : next_state;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op      <= OP_READ_STATUS;
      addr    <= '0;
      data    <= '0;
      refused <= 1'b0;
      polls   <= '0;
    end else if (take) begin
      op      <= cmd_op_i;
      addr    <= cmd_addr_i;
      data    <= cmd_data_i;
      refused <= refuse;
      polls   <= '0;
    end else if (state == ST_READ && bus_done) begin
      polls <= polls + POLL_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      issued <= 1'b0;
    end else if (bus_done) begin
      issued <= 1'b0;
    end else if (bus_req && bus_ready) begin
      issued <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Answers and suspend tracking
  // ----------------------------------------------------------------------
  // Bit 0 is stripped and the lower flags are qualified by ready, so users
  // never act on a value the device has not settled.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_status_o      <= OST_RESET;
      rsp_flags_valid_o <= 1'b0;
      rsp_data_o        <= '0;
      rsp_refused_o     <= 1'b0;
    end else begin
      if (state == ST_READ && bus_done && op != OP_READ_ARRAY) begin
        rsp_status_o      <= sbyte & OST_USE_MASK;
        rsp_flags_valid_o <= sbyte[OST_READY];
      end
      if (state == ST_READ && bus_done) begin
        rsp_data_o <= bus_rdata;
      end
      if (next_state == ST_RESP) begin
        rsp_refused_o <= (state == ST_IDLE) ? refuse : refused;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      suspended_o <= 1'b0;
      susp_addr   <= '0;
      prog_addr   <= '0;
    end else begin
      if (state == ST_DATA && bus_done) begin
        prog_addr <= addr;
      end
      if (state == ST_READ && bus_done && op == OP_SUSPEND && susp_seen) begin
        suspended_o <= 1'b1;
        susp_addr   <= prog_addr;
      end else if (state == ST_CMD && bus_done && op == OP_RESUME) begin
        suspended_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Protection levels
  // ----------------------------------------------------------------------
  // Supply and unlock levels are frozen while suspended: the interrupted
  // program must resume under the levels it started with.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rp_n_o      <= 1'b0;
      rp_unlock_o <= 1'b0;
      vpp_en_o    <= 1'b0;
    end else if (state == ST_IDLE && !suspended_o) begin
      rp_n_o      <= !powerdown_i;
      rp_unlock_o <= unlock_i && !powerdown_i;
      vpp_en_o    <= write_enable_i;
    end
  end

  fws_bus_cycle #(.ADDR_W (ADDR_W), .DATA_W (DATA_W)) u_bus (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .req_i     (bus_req),
    .write_i   (bus_write),
    .addr_i    (addr),
    .wdata_i   (bus_wdata),
    .ready_o   (bus_ready),
    .done_o    (bus_done),
    .rdata_o   (bus_rdata),
    .ce_n_o    (ce_n_o),
    .we_n_o    (we_n_o),
    .oe_n_o    (oe_n_o),
    .addr_o    (addr_o),
    .dq_o      (dq_o),
    .dq_oe_n_o (dq_oe_n_o),
    .dq_i      (dq_i)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_suspend_written;
    state == ST_CMD && op == OP_SUSPEND && bus_done;
  endsequence
  a_susp_refuse_prog: assert property (
    take && suspended_o && cmd_op_i == OP_PROGRAM |=> rsp_valid_o && rsp_refused_o)
    else $error("program order not refused during suspend");
  a_susp_then_status: assert property (
    s_suspend_written |=> state == ST_STAT_CMD ##1 (state == ST_STAT_CMD)[*1])
    else $error("suspend not followed by status command");
  a_status_byte_sent: assert property (
    state == ST_STAT_CMD && bus_req |-> bus_wdata[7:0] == CMD_READ_STATUS)
    else $error("wrong byte sent after suspend");
  a_flags_gate_ready: assert property (
    rsp_valid_o && !rsp_status_o[OST_READY] |-> !rsp_flags_valid_o)
    else $error("flags reported valid while busy");
  a_mask_reserved: assert property (
    rsp_valid_o |-> rsp_status_o[OST_RSVD] == 1'b0)
    else $error("reserved status bit not masked");
  a_no_clear_susp: assert property (
    suspended_o && state == ST_CMD |-> op != OP_CLEAR && op != OP_PROGRAM)
    else $error("forbidden command issued during suspend");
  a_levels_frozen: assert property (
    suspended_o && $past(suspended_o) |-> $stable(vpp_en_o) && $stable(rp_unlock_o))
    else $error("protection levels changed during suspend");
endmodule // fws_flash_host

`default_nettype wire

// >>> fws_flash_model.sv
// Behavioural model of the parallel flash seen by the host controller.
// Assumes host strobes change on clk_i edges; the model samples at negedge.
`timescale 1ns/1ns
`default_nettype none

module fws_flash_model #(
  parameter int          PROG_CYC  = 60,
  parameter int          SUSP_LAT  = 3,
  parameter logic        BOOT_TOP  = 1'b0,
  parameter logic [17:0] BOOT_SPAN = 18'h0_4000
) (
  // Timing reference
  input  wire logic        clk_i,
  // Flash pins
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        rp_n_i,
  input  wire logic        rp_unlock_i,
  input  wire logic        vpp_en_i,
  output      logic [7:0]  dq_o,
  // Host discipline
  output      logic        bad_cmd_o
);
  logic [7:0]  mem [0:262143];
  logic        we_q, run, susp, susp_req, want_data, stat_mode;
  logic [7:0]  err, last, pdata;
  logic [17:0] paddr;
  int          left, lat;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  wire       wr_edge = we_n_i && !we_q && !ce_n_i && rp_n_i;
  wire       busy    = run && !susp;
  wire       boot    = BOOT_TOP ? (addr_i >= 18'h0_0000 - BOOT_SPAN) : (addr_i < BOOT_SPAN);
  // Bits 6..0 are scrambled while busy so a host that trusts them shows up
  wire [7:0] stat    = busy ? {1'b0, ~last[6:0]} :
                       {1'b1, 1'b0, err[5:3], susp, err[1], 1'b1};
  wire       drive   = !ce_n_i && !oe_n_i && rp_n_i;
  assign dq_o = drive ? (stat_mode ? stat : mem[addr_i]) : ~last;

  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {we_q, run, susp, susp_req, want_data, stat_mode, bad_cmd_o} = 7'h01 << 6;
    {err, last, pdata} = '0;
  end

  // ----------------------------------------------------------------------
  // Command decoder and write state machine
  // ----------------------------------------------------------------------
  always @(negedge clk_i) begin
    we_q <= we_n_i;
    if (drive) last <= dq_o;
    if (!rp_n_i) begin
      {run, susp, susp_req, want_data, stat_mode} <= '0;
      err <= 8'h00;
    end else if (wr_edge && want_data) begin
      want_data <= 1'b0;
      if (!vpp_en_i) err <= err | 8'h18;
      else if (boot && !rp_unlock_i) err <= err | 8'h12;
      else begin
        run   <= 1'b1;
        left  <= PROG_CYC;
        paddr <= addr_i;
        pdata <= dq_i;
      end
    end else if (wr_edge) begin
      if (susp && !(dq_i inside {8'hFF, 8'h70, 8'hD0})) bad_cmd_o <= 1'b1;
      stat_mode <= (dq_i != 8'hFF);
      case (dq_i)
        8'h40: want_data <= 1'b1;
        8'hB0: if (busy) begin
          susp_req <= 1'b1;
          lat      <= SUSP_LAT;
        end
        8'hD0: if (susp) begin
          susp     <= 1'b0;
          susp_req <= 1'b0;
        end
        8'h50: if (!susp) err <= 8'h00;
        default: ;
      endcase
    end else if (susp_req && !susp) begin
      // The algorithm only stops at its next safe point
      if (lat == 0) susp <= 1'b1;
      else lat <= lat - 1;
    end else if (busy) begin
      if (left == 0) begin
        run         <= 1'b0;
        mem[paddr]  <= mem[paddr] & pdata;
      end else left <= left - 1;
    end
  end
endmodule // fws_flash_model

`default_nettype wire

// >>> tb.sv
// Self-checking bench: flash host controller driving the flash model.
// Assumes the model's program time of 60 cycles and short suspend latency.
`timescale 1ns/1ns
`default_nettype none

module tb
  import fws_pkg::*;
;
  typedef struct {logic refused; logic [7:0] stat, smask, data, dmask;} fws_exp_type;

  logic        clk_i = 0, rst_i = 1, cmd_valid_i = 0;
  logic        powerdown_i = 0, unlock_i = 0, write_enable_i = 1;
  fws_op_type  cmd_op_i = OP_READ_STATUS;
  logic [17:0] cmd_addr_i = '0, addr_o, pa, ba;
  logic [7:0]  cmd_data_i = '0, rsp_status_o, rsp_data_o, dq_o, flash_dq, pd;
  logic        cmd_ready_o, rsp_valid_o, rsp_refused_o, rsp_flags_valid_o, suspended_o;
  logic        rp_n_o, rp_unlock_o, vpp_en_o, ce_n_o, we_n_o, oe_n_o, dq_oe_n_o, bad_cmd;
  logic [31:0] seed = 32'h0000_0025;
  int          n_errors = 0, total_checks = 0, cycles = 0;
  fws_exp_type notes[$];
  fws_exp_type e;
  // Shared data wire: host drives only while its enable is low
  wire  [7:0]  dq_bus = !dq_oe_n_o ? dq_o : flash_dq;

  fws_flash_host dut_u (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
    .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_refused_o(rsp_refused_o),
    .rsp_status_o(rsp_status_o), .rsp_flags_valid_o(rsp_flags_valid_o),
    .rsp_data_o(rsp_data_o), .suspended_o(suspended_o), .powerdown_i(powerdown_i),
    .unlock_i(unlock_i), .write_enable_i(write_enable_i), .rp_n_o(rp_n_o),
    .rp_unlock_o(rp_unlock_o), .vpp_en_o(vpp_en_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
    .oe_n_o(oe_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dq_i(dq_bus));

  fws_flash_model flash_u (.clk_i(clk_i), .ce_n_i(ce_n_o), .we_n_i(we_n_o), .oe_n_i(oe_n_o),
    .addr_i(addr_o), .dq_i(dq_bus), .rp_n_i(rp_n_o), .rp_unlock_i(rp_unlock_o),
    .vpp_en_i(vpp_en_o), .dq_o(flash_dq), .bad_cmd_o(bad_cmd));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // One order: note the expected answer, hand it over, wait for the answer
  task automatic do_op(input fws_op_type op, input logic [17:0] a, input logic [7:0] d,
                       input logic r, input logic [7:0] s, sm, x, xm);
    int n;
    notes.push_back(fws_exp_type'{r, s, sm, x, xm});
    cmd_op_i    = op;
    cmd_addr_i  = a;
    cmd_data_i  = d;
    cmd_valid_i = 1'b1;
    do @(posedge clk_i); while (cmd_ready_o !== 1'b1);
    #1 cmd_valid_i = 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400) check(8'h00, 8'h01);
    #1;
  endtask

  // Poll without judging until ready, then judge one full status read
  task automatic wait_ready(input logic [7:0] s);
    int k;
    for (k = 0; k < 30; k++) begin
      do_op(OP_READ_STATUS, '0, '0, 1'b0, '0, '0, '0, '0);
      if (rsp_status_o[7] === 1'b1) break;
    end
    do_op(OP_READ_STATUS, '0, '0, 1'b0, s, 8'hFF, '0, '0);
  endtask

  // ----------------------------------------------------------------------
  // Answer monitor, clock and hang guard
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (rsp_valid_o === 1'b1) begin
      if (notes.size() == 0) check(8'h00, 8'h01);
      else begin
        e = notes.pop_front();
        check({7'h00, rsp_refused_o}, {7'h00, e.refused});
        check(rsp_status_o & e.smask, e.stat & e.smask);
        check({7'h00, rsp_status_o[0]}, 8'h00);
        check(rsp_data_o & e.dmask, e.data & e.dmask);
      end
    end
  end

  initial forever #50 clk_i = ~clk_i;

  initial begin
    wait (cycles >= 20000);
    n_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    #1 rst_i = 1'b0;
    pa = 18'h2_0000 | 18'(xorshift() & 32'h0000_FFFF);
    pd = 8'(xorshift());
    ba = pa ^ 18'h0_0100;
    do_op(OP_PROGRAM, pa, pd, 1'b0, '0, '0, '0, '0);
    do_op(OP_READ_STATUS, '0, '0, 1'b0, 8'h00, 8'h81, '0, '0);
    check({7'h00, rsp_flags_valid_o}, 8'h00);
    do_op(OP_SUSPEND, '0, '0, 1'b0, 8'h84, 8'hFF, '0, '0);
    check({7'h00, suspended_o}, 8'h01);
    do_op(OP_READ_STATUS, '0, '0, 1'b0, 8'h84, 8'hFF, '0, '0);
    do_op(OP_READ_ARRAY, ba, '0, 1'b0, '0, '0, 8'hFF, 8'hFF);
    do_op(OP_READ_ARRAY, pa, '0, 1'b1, '0, '0, '0, '0);
    do_op(OP_CLEAR, '0, '0, 1'b1, '0, '0, '0, '0);
    do_op(OP_PROGRAM, ba, pd, 1'b1, '0, '0, '0, '0);
    do_op(fws_op_type'(3'h6), '0, '0, 1'b1, '0, '0, '0, '0);
    do_op(OP_RESUME, '0, '0, 1'b0, '0, '0, '0, '0);
    check({7'h00, suspended_o}, 8'h00);
    do_op(OP_READ_STATUS, '0, '0, 1'b0, 8'h00, 8'h81, '0, '0);
    wait_ready(8'h80);
    do_op(OP_READ_ARRAY, pa, '0, 1'b0, '0, '0, pd, 8'hFF);
    check({7'h00, bad_cmd}, 8'h00);
    do_op(OP_SUSPEND, '0, '0, 1'b0, 8'h80, 8'hFF, '0, '0);
    check({7'h00, suspended_o}, 8'h00);
    do_op(OP_PROGRAM, 18'h0_0010, pd, 1'b0, '0, '0, '0, '0);
    wait_ready(8'h92);
    do_op(OP_CLEAR, '0, '0, 1'b0, '0, '0, '0, '0);
    wait_ready(8'h80);
    unlock_i = 1'b1;
    pd = 8'(xorshift());
    do_op(OP_PROGRAM, 18'h0_0020, pd, 1'b0, '0, '0, '0, '0);
    wait_ready(8'h80);
    do_op(OP_READ_ARRAY, 18'h0_0020, '0, 1'b0, '0, '0, pd, 8'hFF);
    unlock_i = 1'b0;
    write_enable_i = 1'b0;
    do_op(OP_PROGRAM, ba, pd, 1'b0, '0, '0, '0, '0);
    wait_ready(8'h98);
    do_op(OP_CLEAR, '0, '0, 1'b0, '0, '0, '0, '0);
    wait_ready(8'h80);
    // Power-down must override unlock, and the supply follows its enable
    powerdown_i = 1'b1;
    unlock_i    = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 check({5'h00, rp_n_o, rp_unlock_o, vpp_en_o}, 8'h00);
    powerdown_i    = 1'b0;
    write_enable_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 check({5'h00, rp_n_o, rp_unlock_o, vpp_en_o}, 8'h07);
    unlock_i = 1'b0;
    wait_ready(8'h80);
    give_verdict();
  end
endmodule // tb

`default_nettype wire
